/* File: design/fsk_mod_ctrl.sv */
// Contract
// - Decode three-bit modulation select into schemes
// - Calibrate on lock entry and RX/TX swap
// - Use and store finished calibration word
// - Centre equals base plus index times step
// - Base from 28-bit word, B and D
// - Band select picks divider four or eight
// - Reference halver picks divider one or two
// - Double-rate crystal halves the digital clock
// - Deviation from mantissa and exponent with rounding
// - Inner symbols use one third deviation
// - Two-level map code two inverts polarity
// - Four-level maps swap inner/outer and negate
// - Pair bit swap reverses bits per pair
// - Gaussian filter, eight taps, BT selectable
// - Linear interpolation factor from rate exponent
// - Equalizer off, single or dual pass
`timescale 1ns/10ps
`default_nettype none
module fsk_mod_ctrl
	import fsk_ctrl_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire logic double_rate_xtal_i,
	input wire logic [2:0] modulation_select_i,
	input wire logic [BASE_W-1:0] base_frequency_word_i,
	input wire logic band_select_i,
	input wire logic reference_halver_i,
	input wire logic [7:0] channel_step_i,
	input wire logic [7:0] channel_index_i,
	input wire logic [7:0] dev_mantissa_i,
	input wire logic [3:0] dev_exponent_i,
	input wire logic [1:0] const_map_i,
	input wire logic pair_bit_swap_i,
	input wire logic gauss_bandwidth_select_i,
	input wire logic shaping_interp_enable_i,
	input wire logic [3:0] rate_exponent_i,
	input wire logic [1:0] equalizer_control_i,
	input wire logic [2:0] pump_current_select_i,
	input wire logic detector_split_enable_i,
	input wire logic [1:0] radio_state_i,
	input wire logic cal_disable_i,
	input wire logic [CAL_W-1:0] cal_word_tx_i,
	input wire logic [CAL_W-1:0] cal_word_rx_i,
	input wire logic cal_done_i,
	input wire logic [CAL_W-1:0] cal_result_i,
	input wire logic sample_tick_i,
	input wire logic [7:0] data_i,
	input wire logic data_valid_i,
	output logic data_ready_o,
	output logic dig_tick_o,
	output logic is_fsk_o,
	output logic is_four_level_o,
	output logic is_gauss_o,
	output logic is_ask_o,
	output logic is_polar_o,
	output logic is_cw_o,
	output logic cal_start_o,
	output logic cal_busy_o,
	output logic [CAL_W-1:0] cal_word_o,
	output logic [CAL_W-1:0] cal_store_tx_o,
	output logic [CAL_W-1:0] cal_store_rx_o,
	output logic [WORD_W-1:0] chan_word_o,
	output logic [WORD_W-1:0] dev_word_o,
	output logic [WORD_W-1:0] freq_word_o,
	output logic [6:0] interp_factor_o,
	output logic [1:0] eq_mode_o,
	output logic [2:0] pump_current_o,
	output logic detector_split_o
);
	// ==========================================================
	// Digital clock enable
	// Double-rate crystals run the logic on every second edge
	logic half_r;
	logic tick;
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			half_r <= 1'b0;
		else if (ce_i)
			half_r <= ~half_r;
	end
	assign tick = ce_i & (~double_rate_xtal_i | half_r);
	assign dig_tick_o = tick;

	// ==========================================================
	// Mode decode
	logic fsk_mode;
	assign fsk_mode = (modulation_select_i[2] == 1'b0);
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			is_fsk_o <= 1'b0;
			is_four_level_o <= 1'b0;
			is_gauss_o <= 1'b0;
			is_ask_o <= 1'b0;
			is_polar_o <= 1'b0;
			is_cw_o <= 1'b0;
			eq_mode_o <= EQ_OFF;
			pump_current_o <= 3'h0;
			detector_split_o <= 1'b0;
		end
		else if (tick)
		begin
			is_fsk_o <= fsk_mode;
			is_four_level_o <= fsk_mode & modulation_select_i[0];
			is_gauss_o <= fsk_mode & modulation_select_i[1];
			is_ask_o <= (modulation_select_i == MOD_ASK);
			is_polar_o <= (modulation_select_i == MOD_POLAR);
			is_cw_o <= (modulation_select_i == MOD_CW);
			// Equalizer only has meaning for four-level reception
			eq_mode_o <= (fsk_mode & modulation_select_i[0]) ? equalizer_control_i : EQ_OFF;
			pump_current_o <= pump_current_select_i;
			detector_split_o <= detector_split_enable_i;
		end
	end

	// ==========================================================
	// Channel and deviation words, lsb = fxo / 2^23
	logic [4:0] bd; // Product B times D: 4, 8 or 16
	logic [WORD_W-1:0] base_w;
	logic [WORD_W-1:0] step_w;
	logic [WORD_W-1:0] dev_raw;
	logic [WORD_W-1:0] dev_rnd;
	logic [WORD_W-1:0] dev_full;
	assign bd = (band_select_i ? 5'h08 : 5'h04) << reference_halver_i;
	// fbase = fxo*BASE_FREQUENCY_WORD*2/(2^20*B*D) becomes BASE_FREQUENCY_WORD*16/(B*D) in this unit
	always_comb
	begin
		case (bd)
			5'h04: base_w = {2'h0, base_frequency_word_i, 2'h0};
			5'h08: base_w = {3'h0, base_frequency_word_i, 1'h0};
			default: base_w = {4'h0, base_frequency_word_i};
		endcase
	end
	assign step_w = WORD_W'({16'h0, channel_step_i} * {16'h0, channel_index_i}) << CHAN_SHIFT;
	// Raw deviation before the D*B/8 scale, doubled so that halving can round
	assign dev_raw = (dev_exponent_i == 4'h0) ? {23'h0, dev_mantissa_i, 1'b0} :
		WORD_W'({DEV_BASE_9 + {1'b0, dev_mantissa_i}, 1'b0}) << (dev_exponent_i - 4'h1);
	// round(raw*D*B/8): halve with rounding at D*B = 4, else scale exactly
	always_comb
	begin
		case (bd)
			5'h04: dev_rnd = ((dev_raw >> 1) + 32'h1) >> 1;
			5'h08: dev_rnd = dev_raw >> 1;
			default: dev_rnd = dev_raw;
		endcase
	end
	// fdev = fxo/2^19 * r/(D*B) gives r*16/(D*B) in this unit
	always_comb
	begin
		case (bd)
			5'h04: dev_full = dev_rnd << 2;
			5'h08: dev_full = dev_rnd << 1;
			default: dev_full = dev_rnd;
		endcase
	end
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			chan_word_o <= 32'h0;
			dev_word_o <= 32'h0;
		end
		else if (tick)
		begin
			chan_word_o <= base_w + step_w;
			dev_word_o <= dev_full;
		end
	end

	// ==========================================================
	// Synthesizer calibration sequencer
	cal_state_t cal_state_r;
	logic [1:0] prev_state_r;
	logic cal_to_rx_r;
	logic cal_trig;
	assign cal_trig = ((prev_state_r == RS_READY) && (radio_state_i != RS_READY)) ||
		((prev_state_r == RS_RX) && (radio_state_i == RS_TX)) ||
		((prev_state_r == RS_TX) && (radio_state_i == RS_RX));
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			cal_state_r <= CAL_IDLE;
			prev_state_r <= RS_READY;
			cal_to_rx_r <= 1'b0;
			cal_start_o <= 1'b0;
			cal_store_tx_o <= 7'h00;
			cal_store_rx_o <= 7'h00;
		end
		else if (tick)
		begin
			prev_state_r <= radio_state_i;
			cal_start_o <= 1'b0;
			case (cal_state_r)
				CAL_IDLE:
				begin
					// With calibration off the preloaded words are used as they stand
					if (cal_trig && !cal_disable_i)
					begin
						cal_state_r <= CAL_RUN;
						cal_start_o <= 1'b1;
						cal_to_rx_r <= (radio_state_i == RS_RX);
					end
				end
				CAL_RUN:
				begin
					if (cal_done_i)
					begin
						cal_state_r <= CAL_IDLE;
						if (cal_to_rx_r)
							cal_store_rx_o <= cal_result_i;
						else
							cal_store_tx_o <= cal_result_i;
					end
				end
				default: cal_state_r <= CAL_IDLE;
			endcase
		end
	end
	assign cal_busy_o = (cal_state_r == CAL_RUN);
	// Word applied to the synthesizer follows the direction in use
	assign cal_word_o = cal_disable_i ? ((radio_state_i == RS_RX) ? cal_word_rx_i : cal_word_tx_i) :
		((radio_state_i == RS_RX) ? cal_store_rx_o : cal_store_tx_o);

	// ==========================================================
	// Two-entry byte buffer; drains only at symbol boundaries
	logic [7:0] buf_mem_r [2];
	logic wr_ptr_r;
	logic rd_ptr_r;
	logic [1:0] count_r;
	logic push;
	logic pop;
	logic [2:0] phase_r;
	logic sym_edge;
	logic [2:0] syms_left_r;
	assign data_ready_o = (count_r != 2'h2);
	assign push = tick & data_valid_i & data_ready_o;
	assign sym_edge = tick & sample_tick_i & (phase_r == 3'h7);
	assign pop = sym_edge & fsk_mode & (syms_left_r == 3'h0) & (count_r != 2'h0);
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r <= 2'h0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= ~wr_ptr_r;
			if (pop)
				rd_ptr_r <= ~rd_ptr_r;
			count_r <= count_r + 2'(push) - 2'(pop);
		end
	end
	always_ff @(posedge clk_i)
	begin
		if (push)
			buf_mem_r[wr_ptr_r] <= data_i;
	end

	// ==========================================================
	// Symbol extraction and constellation mapping
	logic [7:0] shreg_r;
	logic [7:0] cur_byte;
	logic [1:0] sym;
	logic signed [2:0] level;
	logic signed [2:0] level_r;
	logic four_lvl;
	assign four_lvl = modulation_select_i[0];
	assign cur_byte = (syms_left_r == 3'h0) ? buf_mem_r[rd_ptr_r] : shreg_r;
	assign sym = pair_bit_swap_i ? {cur_byte[6], cur_byte[7]} : cur_byte[7:6];
	always_comb
	begin
		level = 3'sd0;
		if (!four_lvl)
			level = (cur_byte[7] ^ const_map_i[1]) ? LVL_OUT_P : LVL_OUT_N;
		else
		begin
			case (sym)
				2'b01: level = const_map_i[0] ? LVL_OUT_N : LVL_IN_N;
				2'b00: level = const_map_i[0] ? LVL_IN_N : LVL_OUT_N;
				2'b10: level = const_map_i[0] ? LVL_OUT_P : LVL_IN_P;
				default: level = const_map_i[0] ? LVL_IN_P : LVL_OUT_P;
			endcase
			if (const_map_i[1])
				level = -level;
		end
	end
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			phase_r <= 3'h0;
			syms_left_r <= 3'h0;
			shreg_r <= 8'h00;
			level_r <= 3'sd0;
		end
		else if (tick && sample_tick_i)
		begin
			phase_r <= phase_r + 3'h1;
			if (phase_r == 3'h7)
			begin
				// An empty buffer leaves the carrier unmodulated
				if (fsk_mode && (syms_left_r != 3'h0 || count_r != 2'h0))
				begin
					level_r <= level;
					shreg_r <= four_lvl ? {cur_byte[5:0], 2'h0} : {cur_byte[6:0], 1'h0};
					syms_left_r <= (syms_left_r != 3'h0) ? syms_left_r - 3'h1 : (four_lvl ? 3'h3 : 3'h7);
				end
				else
					level_r <= 3'sd0;
			end
		end
	end

	// ==========================================================
	// Gaussian shaping: eight-tap FIR over the sample history
	logic signed [2:0] hist_r [TAPS];
	logic signed [11:0] prod [TAPS];
	logic signed [11:0] fir_sum;
	logic [63:0] taps;
	assign taps = gauss_bandwidth_select_i ? TAPS_BT05 : TAPS_BT1;
	genvar g;
	generate
		for (g = 0; g < TAPS; g++)
		begin : g_tap
			always_ff @(posedge clk_i)
			begin
				if (srst_i)
					hist_r[g] <= 3'sd0;
				else if (tick && sample_tick_i)
					hist_r[g] <= (g == 0) ? level_r : hist_r[(g == 0) ? 0 : g - 1];
			end
			assign prod[g] = 12'(hist_r[g]) * $signed({4'h0, taps[g*8 +: 8]});
		end
	endgenerate
	always_comb
	begin
		fir_sum = 12'sd0;
		for (int i = 0; i < TAPS; i++)
			fir_sum = fir_sum + prod[i];
	end

	// ==========================================================
	// Linear interpolation between successive filter samples
	logic [2:0] interp_shift;
	logic interp_on;
	logic signed [11:0] shp_cur_r;
	logic signed [11:0] shp_prev_r;
	logic [5:0] sub_r;
	logic signed [11:0] shaped;
	logic signed [18:0] delta_mul;
	assign interp_shift = (rate_exponent_i < INTERP_E_LO) ? 3'(INTERP_SHIFT_MAX) :
		3'(4'(INTERP_SHIFT_MAX) + INTERP_E_LO - rate_exponent_i);
	assign interp_on = shaping_interp_enable_i && (rate_exponent_i < INTERP_E_OFF);
	assign interp_factor_o = interp_on ? (7'h01 << interp_shift) : 7'h01;
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			shp_cur_r <= 12'sd0;
			shp_prev_r <= 12'sd0;
			sub_r <= 6'h0;
		end
		else if (tick)
		begin
			if (sample_tick_i)
			begin
				// Restart from the old sample; the ramp stops one sub-step short of the target
				shp_prev_r <= shp_cur_r;
				shp_cur_r <= fir_sum;
				sub_r <= 6'h0;
			end
			// Sub-step holds at the last point until the next sample
			else if ({1'b0, sub_r} < interp_factor_o - 7'h01)
				sub_r <= sub_r + 6'h1;
		end
	end
	assign delta_mul = 19'(shp_cur_r - shp_prev_r) * $signed({13'h0, sub_r});
	assign shaped = interp_on ? 12'(shp_prev_r + 12'(delta_mul >>> interp_shift)) : shp_cur_r;

	// ==========================================================
	// Instantaneous frequency word
	// Level is in thirds of the deviation; non-Gaussian modes skip the filter
	logic signed [11:0] lvl_q;
	logic [WORD_W-1:0] dev_third;
	logic signed [47:0] dev_prod;
	assign lvl_q = (fsk_mode && modulation_select_i[1]) ? shaped : 12'(level_r) <<< SHAPE_FRAC;
	assign dev_third = dev_word_o / 32'd3;
	assign dev_prod = 48'($signed({1'b0, dev_third})) * 48'(lvl_q);
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			freq_word_o <= 32'h0;
		else if (tick)
			freq_word_o <= fsk_mode ? chan_word_o + 32'(dev_prod >>> SHAPE_FRAC) : chan_word_o;
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	chk_cal_start_pulse: assert property (cal_start_o |=> !cal_start_o)
		else $error("calibration start longer than one cycle");
	chk_cal_on_lock: assert property (tick && cal_state_r == CAL_IDLE && !cal_disable_i
		&& prev_state_r == RS_READY && radio_state_i == RS_LOCK |=> cal_start_o && cal_busy_o)
		else $error("no calibration on lock entry");
	chk_cal_off_quiet: assert property (cal_disable_i && !cal_busy_o |=> !cal_start_o)
		else $error("calibration started while disabled");
	chk_cal_store: assert property (tick && cal_busy_o && cal_done_i && cal_to_rx_r
		|=> cal_store_rx_o == $past(cal_result_i))
		else $error("calibration result not stored");
	chk_half_clock: assert property (ce_i && double_rate_xtal_i && tick ##1 double_rate_xtal_i |-> !tick)
		else $error("double rate crystal not halved");
	chk_mode_decode: assert property (tick && modulation_select_i == MOD_4GFSK
		|=> is_fsk_o && is_four_level_o && is_gauss_o && !is_cw_o)
		else $error("modulation decode wrong");
	chk_chan_word: assert property (tick |=> chan_word_o == $past((WORD_W'(base_frequency_word_i)
		<< (3'd2 - 3'(band_select_i) - 3'(reference_halver_i))) + (WORD_W'(channel_step_i)
		* WORD_W'(channel_index_i) << CHAN_SHIFT)))
		else $error("channel word wrong");
	chk_two_level_map: assert property (!four_lvl && const_map_i == 2'h0 && cur_byte[7] |-> level == LVL_OUT_P)
		else $error("two level map wrong");
	chk_interp_off: assert property (rate_exponent_i == INTERP_E_OFF |-> interp_factor_o == 7'h01)
		else $error("interpolation not off at top exponent");
	chk_buf_bound: assert property (count_r == 2'h2 |-> !data_ready_o ##0 !push)
		else $error("buffer overfilled");
	chk_cw_word: assert property (tick && is_cw_o && modulation_select_i == MOD_CW |=> freq_word_o == $past(chan_word_o))
		else $error("carrier word carries deviation");
	cov_cal_done: cover property (cal_busy_o && cal_done_i && tick);
	cov_buf_full: cover property (count_r == 2'h2 && data_valid_i);
	cov_four_gauss: cover property (is_gauss_o && is_four_level_o && sym_edge && pop);
	cov_interp: cover property (interp_on && sub_r == 6'h3f);
endmodule // fsk_mod_ctrl
`default_nettype wire

/* File: design/fsk_ctrl_pkg.sv */
package fsk_ctrl_pkg;
	// ==========================================================
	// Modulation select codes
	localparam logic [2:0] MOD_2FSK = 3'h0;
	localparam logic [2:0] MOD_4FSK = 3'h1;
	localparam logic [2:0] MOD_2GFSK = 3'h2;
	localparam logic [2:0] MOD_4GFSK = 3'h3;
	localparam logic [2:0] MOD_ASK = 3'h5;
	localparam logic [2:0] MOD_POLAR = 3'h6;
	localparam logic [2:0] MOD_CW = 3'h7;
	// ==========================================================
	// Radio states seen by the calibration sequencer
	localparam logic [1:0] RS_READY = 2'h0;
	localparam logic [1:0] RS_LOCK = 2'h1;
	localparam logic [1:0] RS_RX = 2'h2;
	localparam logic [1:0] RS_TX = 2'h3;
	// ==========================================================
	// Widths
	localparam int BASE_W = 28;
	localparam int CAL_W = 7;
	localparam int WORD_W = 32;
	localparam int LVL_W = 3;
	localparam int TAPS = 8;
	// ==========================================================
	// Frequency word scaling, lsb = fxo / 2^23
	localparam int CHAN_SHIFT = 8;
	localparam int DEV_BASE = 256;
	localparam logic [8:0] DEV_BASE_9 = 9'h100;
	// Shaped level carries 6 fraction bits, unit is one third of deviation
	localparam int SHAPE_FRAC = 6;
	localparam int INTERP_SHIFT_MAX = 6;
	localparam logic [3:0] INTERP_E_LO = 4'h5;
	localparam logic [3:0] INTERP_E_OFF = 4'hb;
	// ==========================================================
	// Symbol levels in thirds of deviation
	localparam logic signed [2:0] LVL_OUT_N = -3'sd3;
	localparam logic signed [2:0] LVL_IN_N = -3'sd1;
	localparam logic signed [2:0] LVL_IN_P = 3'sd1;
	localparam logic signed [2:0] LVL_OUT_P = 3'sd3;
	// ==========================================================
	// Gaussian taps per symbol, each set sums to 64; tap 0 in low byte
	localparam logic [63:0] TAPS_BT1 = 64'h00_02_0a_14_14_0a_02_00;
	localparam logic [63:0] TAPS_BT05 = 64'h02_06_0a_0e_0e_0a_06_02;
	// ==========================================================
	// Equalizer control codes
	localparam logic [1:0] EQ_OFF = 2'h0;
	localparam logic [1:0] EQ_SINGLE = 2'h1;
	localparam logic [1:0] EQ_DUAL = 2'h2;
	// ==========================================================
	// Calibration sequencer states
	typedef enum logic [1:0] {
		CAL_IDLE = 2'b01,
		CAL_RUN = 2'b10
	} cal_state_t;
endpackage

/* File: tb/fsk_mod_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module fsk_mod_ctrl_tb
	import fsk_ctrl_pkg::*;
;
	// ==========================================================
	// Stimulus and observed signals
	logic clk_i, srst_i, ce_i, double_rate_xtal_i, band_select_i, reference_halver_i;
	logic pair_bit_swap_i, gauss_bandwidth_select_i, shaping_interp_enable_i, detector_split_enable_i;
	logic cal_disable_i, cal_done_i, sample_tick_i, data_valid_i;
	logic [2:0] modulation_select_i, pump_current_select_i;
	logic [BASE_W-1:0] base_frequency_word_i;
	logic [7:0] channel_step_i, channel_index_i, dev_mantissa_i, data_i;
	logic [3:0] dev_exponent_i, rate_exponent_i;
	logic [1:0] const_map_i, equalizer_control_i, radio_state_i;
	logic [CAL_W-1:0] cal_word_tx_i, cal_word_rx_i, cal_result_i, cal_word_o, cal_store_tx_o, cal_store_rx_o;
	logic data_ready_o, dig_tick_o, is_fsk_o, is_four_level_o, is_gauss_o, is_ask_o, is_polar_o, is_cw_o;
	logic cal_start_o, cal_busy_o, detector_split_o;
	logic [WORD_W-1:0] chan_word_o, dev_word_o, freq_word_o;
	logic [6:0] interp_factor_o;
	logic [1:0] eq_mode_o;
	logic [2:0] pump_current_o;
	int n_mismatch;
	int samples_checked;

	fsk_mod_ctrl u_dut (
		.clk_i, .srst_i, .ce_i, .double_rate_xtal_i, .modulation_select_i, .base_frequency_word_i,
		.band_select_i, .reference_halver_i, .channel_step_i, .channel_index_i, .dev_mantissa_i,
		.dev_exponent_i, .const_map_i, .pair_bit_swap_i, .gauss_bandwidth_select_i,
		.shaping_interp_enable_i, .rate_exponent_i, .equalizer_control_i, .pump_current_select_i,
		.detector_split_enable_i, .radio_state_i, .cal_disable_i, .cal_word_tx_i, .cal_word_rx_i,
		.cal_done_i, .cal_result_i, .sample_tick_i, .data_i, .data_valid_i, .data_ready_o,
		.dig_tick_o, .is_fsk_o, .is_four_level_o, .is_gauss_o, .is_ask_o, .is_polar_o, .is_cw_o,
		.cal_start_o, .cal_busy_o, .cal_word_o, .cal_store_tx_o, .cal_store_rx_o, .chan_word_o,
		.dev_word_o, .freq_word_o, .interp_factor_o, .eq_mode_o, .pump_current_o, .detector_split_o
	);

	// ==========================================================
	// Clock, 4 ns period
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// ==========================================================
	// Helpers
	task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Outputs are read at the falling edge so all edge updates have landed
	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask

	task automatic ticks(input int n);
		repeat (n)
		begin
			@(posedge clk_i);
			sample_tick_i <= 1'b1;
			@(posedge clk_i);
			sample_tick_i <= 1'b0;
		end
	endtask

	function automatic logic [WORD_W-1:0] exp_chan();
		longint bd;
		bd = (band_select_i ? 8 : 4) * (reference_halver_i ? 2 : 1);
		return WORD_W'(longint'(base_frequency_word_i) * 16 / bd + longint'(channel_step_i) * channel_index_i * 256);
	endfunction

	// Rounding is half up, so the +4 before the divide by eight
	function automatic logic [WORD_W-1:0] exp_dev();
		longint d, b, x;
		d = reference_halver_i ? 2 : 1;
		b = band_select_i ? 8 : 4;
		if (dev_exponent_i == 4'h0)
			x = d * dev_mantissa_i * b;
		else
			x = d * (256 + dev_mantissa_i) * (longint'(1) << (dev_exponent_i - 1)) * b;
		return WORD_W'(((x + 4) >> 3) * 16 / (d * b));
	endfunction

	// Counts start pulses over a short window after a state change
	task automatic to_state(input logic [1:0] s, input int starts);
		int cnt;
		cnt = 0;
		@(posedge clk_i);
		radio_state_i <= s;
		repeat (4)
		begin
			@(negedge clk_i);
			if (cal_start_o === 1'b1)
				cnt++;
		end
		chk(cnt, starts);
	endtask

	task automatic finish_cal(input logic [CAL_W-1:0] v);
		@(posedge clk_i);
		cal_done_i <= 1'b1;
		cal_result_i <= v;
		@(posedge clk_i);
		cal_done_i <= 1'b0;
		settle(2);
		chk(cal_busy_o, 0);
	endtask

	// Constant byte stream; long enough to flush older bytes and let shaping settle
	task automatic stream(input logic [2:0] m, input logic [1:0] map, input logic sw, input logic bt,
		input logic [7:0] byt, input int lvl);
		@(posedge clk_i);
		modulation_select_i <= m;
		const_map_i <= map;
		pair_bit_swap_i <= sw;
		gauss_bandwidth_select_i <= bt;
		data_i <= byt;
		data_valid_i <= 1'b1;
		ticks(260);
		settle(2);
		chk(data_ready_o, 0);
		chk(freq_word_o, exp_chan() + (exp_dev() / 3) * lvl);
	endtask

	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ==========================================================
	// Watchdog, well beyond the roughly 6000 cycles the tests need
	initial
	begin
		repeat (40000) @(posedge clk_i);
		n_mismatch++;
		wrap_up();
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		int cnt;
		n_mismatch = 0;
		samples_checked = 0;
		srst_i = 1'b1;
		ce_i = 1'b1;
		double_rate_xtal_i = 1'b0;
		modulation_select_i = MOD_2FSK;
		base_frequency_word_i = 28'h1a2b3c4;
		band_select_i = 1'b0;
		reference_halver_i = 1'b0;
		channel_step_i = 8'h15;
		channel_index_i = 8'h2a;
		dev_mantissa_i = 8'h3c;
		dev_exponent_i = 4'h0;
		const_map_i = 2'h0;
		pair_bit_swap_i = 1'b0;
		gauss_bandwidth_select_i = 1'b0;
		shaping_interp_enable_i = 1'b0;
		rate_exponent_i = 4'h0;
		equalizer_control_i = EQ_OFF;
		pump_current_select_i = 3'h0;
		detector_split_enable_i = 1'b0;
		radio_state_i = RS_READY;
		cal_disable_i = 1'b0;
		cal_word_tx_i = 7'h35;
		cal_word_rx_i = 7'h4a;
		cal_done_i = 1'b0;
		cal_result_i = 7'h00;
		sample_tick_i = 1'b0;
		data_i = 8'h00;
		data_valid_i = 1'b0;
		settle(16);
		chk(chan_word_o, 0);
		chk(data_ready_o, 1);
		@(posedge clk_i);
		srst_i <= 1'b0;
		// Two pushes without sample ticks fill the buffer
		@(posedge clk_i);
		data_valid_i <= 1'b1;
		settle(4);
		chk(data_ready_o, 0);
		@(posedge clk_i);
		data_valid_i <= 1'b0;
		// Every modulation code; code 4 is unassigned
		for (int i = 0; i < 8; i++)
		begin
			if (i != 4)
			begin
				@(posedge clk_i);
				modulation_select_i <= 3'(i);
				settle(2);
				chk({is_fsk_o, is_four_level_o, is_gauss_o, is_ask_o, is_polar_o, is_cw_o},
					{i < 4, i == 1 || i == 3, i == 2 || i == 3, i == 5, i == 6, i == 7});
			end
		end
		// Band and reference divider combinations against exponents and index extremes
		@(posedge clk_i);
		modulation_select_i <= MOD_2FSK;
		for (int k = 0; k < 4; k++)
		begin
			for (int e = 0; e < 16; e += 3)
			begin
				@(posedge clk_i);
				band_select_i <= k[0];
				reference_halver_i <= k[1];
				channel_index_i <= 8'(k * 85);
				dev_exponent_i <= 4'(e);
				settle(3);
				chk(chan_word_o, exp_chan());
				chk(dev_word_o, exp_dev());
			end
		end
		@(posedge clk_i);
		band_select_i <= 1'b0;
		reference_halver_i <= 1'b0;
		channel_index_i <= 8'h2a;
		dev_exponent_i <= 4'h0;
		// Clock enable low must hold the last channel word despite new inputs
		ce_i <= 1'b0;
		settle(3);
		chk(dig_tick_o, 0);
		chk(chan_word_o, 32'(base_frequency_word_i) + 32'h15 * 32'd255 * 32'd256);
		@(posedge clk_i);
		ce_i <= 1'b1;
		// Double-rate reference gives a tick every second cycle
		double_rate_xtal_i <= 1'b1;
		settle(2);
		cnt = 0;
		repeat (8)
		begin
			@(negedge clk_i);
			cnt += int'(dig_tick_o === 1'b1);
		end
		chk(cnt, 4);
		@(posedge clk_i);
		double_rate_xtal_i <= 1'b0;
		// Interpolation factor for rate exponents 0 to 11
		modulation_select_i <= MOD_2GFSK;
		shaping_interp_enable_i <= 1'b1;
		for (int e = 0; e < 12; e++)
		begin
			@(posedge clk_i);
			rate_exponent_i <= 4'(e);
			settle(2);
			chk(interp_factor_o, e < 5 ? 64 : (e < 11 ? 64 >> (e - 5) : 1));
		end
		@(posedge clk_i);
		shaping_interp_enable_i <= 1'b0;
		settle(2);
		chk(interp_factor_o, 1);
		// Equalizer modes in four-level mode, pump and split pass through
		for (int q = 0; q < 3; q++)
		begin
			@(posedge clk_i);
			modulation_select_i <= MOD_4FSK;
			equalizer_control_i <= 2'(q);
			pump_current_select_i <= 3'(q + 1);
			detector_split_enable_i <= q[0];
			settle(2);
			chk({eq_mode_o, pump_current_o, detector_split_o}, {2'(q), 3'(q + 1), q[0]});
		end
		// Calibration on lock entry and direction swaps, then with calibration off
		to_state(RS_TX, 1);
		chk(cal_busy_o, 1);
		finish_cal(7'h1d);
		chk({cal_store_tx_o, cal_word_o}, {7'h1d, 7'h1d});
		to_state(RS_RX, 1);
		finish_cal(7'h62);
		chk({cal_store_rx_o, cal_word_o}, {7'h62, 7'h62});
		to_state(RS_READY, 0);
		to_state(RS_LOCK, 1);
		finish_cal(7'h2b);
		chk({cal_store_tx_o, cal_word_o}, {7'h2b, 7'h2b});
		to_state(RS_READY, 0);
		@(posedge clk_i);
		cal_disable_i <= 1'b1;
		to_state(RS_LOCK, 0);
		chk(cal_word_o, cal_word_tx_i);
		to_state(RS_RX, 0);
		chk(cal_word_o, cal_word_rx_i);
		@(posedge clk_i);
		cal_disable_i <= 1'b0;
		radio_state_i <= RS_READY;
		// Symbol maps, pair swap and shaping at steady state
		stream(MOD_2FSK, 2'h0, 1'b0, 1'b0, 8'hff, 3);
		stream(MOD_2FSK, 2'h2, 1'b0, 1'b0, 8'hff, -3);
		stream(MOD_2FSK, 2'h0, 1'b0, 1'b0, 8'h00, -3);
		stream(MOD_4FSK, 2'h0, 1'b0, 1'b0, 8'h55, -1);
		stream(MOD_4FSK, 2'h1, 1'b0, 1'b0, 8'h55, -3);
		stream(MOD_4FSK, 2'h2, 1'b0, 1'b0, 8'h00, 3);
		stream(MOD_4FSK, 2'h3, 1'b0, 1'b0, 8'h00, 1);
		stream(MOD_4FSK, 2'h0, 1'b1, 1'b0, 8'h55, 1);
		@(posedge clk_i);
		shaping_interp_enable_i <= 1'b1;
		rate_exponent_i <= 4'h7;
		stream(MOD_2GFSK, 2'h0, 1'b0, 1'b0, 8'hff, 3);
		stream(MOD_4GFSK, 2'h0, 1'b0, 1'b1, 8'hff, 3);
		// Drain: an empty buffer leaves the carrier on the channel
		@(posedge clk_i);
		data_valid_i <= 1'b0;
		ticks(260);
		settle(2);
		chk(data_ready_o, 1);
		chk(freq_word_o, exp_chan());
		@(posedge clk_i);
		modulation_select_i <= MOD_CW;
		settle(3);
		chk(freq_word_o, exp_chan());
		wrap_up();
	end
endmodule // fsk_mod_ctrl_tb
`default_nettype wire
